// ===== logic/lcdsi_params.svh
// Register offsets, field positions and reset values of the display status block.
`ifndef LCDSI_PARAMS_SVH
`define LCDSI_PARAMS_SVH

// Byte offsets on the register bus.
`define LCDSI_OFF_CTRL    12'h000
`define LCDSI_OFF_STATUS  12'h004
`define LCDSI_OFF_BIAS    12'h008
`define LCDSI_OFF_FLAGS   12'h00c

// Control register fields.
`define LCDSI_CTRL_EN     0
`define LCDSI_CTRL_DUAL   1
`define LCDSI_CTRL_LDM    2
`define LCDSI_CTRL_BAM    3
`define LCDSI_CTRL_ERM    4
`define LCDSI_CTRL_W      5
`define LCDSI_CTRL_RST    5'h00

// Status register fields; bits above the last one are reserved.
`define LCDSI_ST_LDD      0
`define LCDSI_ST_BAU      1
`define LCDSI_ST_BER      2
`define LCDSI_ST_ABC      3
`define LCDSI_ST_IOL      4
`define LCDSI_ST_IUL      5
`define LCDSI_ST_IOU      6
`define LCDSI_ST_IUU      7
`define LCDSI_ST_OOL      8
`define LCDSI_ST_OUL      9
`define LCDSI_ST_OOU      10
`define LCDSI_ST_OUU      11
`define LCDSI_ST_W        12
`define LCDSI_ST_RST      12'h000

// Bias count field reset value.
`define LCDSI_BIAS_RST    8'h00

`endif

// ===== logic/lcdsi_pkg.sv
// Types shared by the display status block.
package lcdsi_pkg;

    // Controller run state, one-hot.
    typedef enum logic [2:0] {
        LCDSI_IDLE  = 3'b001,
        LCDSI_RUN   = 3'b010,
        LCDSI_DRAIN = 3'b100
    } lcdsi_state_t;

endpackage : lcdsi_pkg

// ===== logic/lcdsi_bias_counter.sv
// Counter of bias pin reversals that reports when the programmed count is used up.
`timescale 1ns/1ps

module lcdsi_bias_counter #(
    parameter int CNT_W = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             bias_pin,
    input  wire logic [CNT_W-1:0] api_field,
    input  wire logic             hold,
    output logic      [CNT_W-1:0] count,
    output logic                  zero_pulse
);

    logic             bias_prev_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic             zero_reg;
    logic             toggle;

    // The pin is synchronous, so a change against last cycle is a reversal.
    assign toggle = bias_pin ^ bias_prev_reg;

    // Remember the pin level for reversal detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_prev_reg <= 1'b0;
        end else begin
            bias_prev_reg <= bias_pin;
        end
    end

    // A zero field switches counting off; the count holds at the field while the host owes a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= '0;
            zero_reg <= 1'b0;
        end else begin
            zero_reg <= 1'b0;
            if (api_field == '0) begin
                cnt_reg <= '0;
            end else if (hold || cnt_reg == '0) begin
                cnt_reg <= api_field;                     // see [RL15]
            end else if (toggle) begin
                if (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    cnt_reg  <= api_field;                // see [RL15]
                    zero_reg <= 1'b1;                     // see [RL14]
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;            // see [RL13]
                end
            end
        end
    end

    assign count      = cnt_reg;
    assign zero_pulse = zero_reg;

endmodule : lcdsi_bias_counter

// ===== logic/lcdsi_status_irq.sv
// Status register, run control and interrupt request of the display controller.
//
// Notes on behaviour
// [RL1] Interrupt request stays high while any contributing status bit stays set.
// [RL2] Writing one clears a sticky status bit; writing zero leaves it alone.
// [RL3] Read-only flags change only by hardware; software writes are ignored.
// [RL4] The interrupt controller masks all requests from this block with its own bit.
// [RL5] Clearing enable lets the current frame finish before the controller stops.
// [RL6] After the last frame ends, stop, set disable-done, request if unmasked.
// [RL7] Reload current pointers from base on enable rise and at end of frame.
// [RL8] Base-update set after channel one reload, cleared by writing one, maskable.
// [RL9] In dual-panel mode base-update waits for both channel reloads.
// [RL10] A DMA bus error sets bus-error status, request if error mask clear.
// [RL11] A bus error does not stop the DMA; transfers continue.
// [RL12] Zero data of a failed read is passed on as ordinary data.
// [RL13] Nonzero bias field loads a counter decremented on each bias pin reversal.
// [RL14] Counter at zero sets bias-count status and requests, with no mask.
// [RL15] After zero the counter reloads and holds until bias-count status is cleared.
// [RL16] Dual-panel only: channel two write to full lower input FIFO sets status.
// [RL17] Dual-panel only: unpacker read of empty lower input FIFO sets status.
// [RL18] Any mode: channel one write to full upper input FIFO sets status.
// [RL19] Any mode: unpacker read of empty upper input FIFO sets status.
// [RL20] Dual-panel only: dither write to full lower output FIFO sets status.
// [RL21] Dual-panel only: pin driver read of empty lower output FIFO sets status.
// [RL22] Any mode: dither write to full upper output FIFO sets status.
// [RL23] Any mode: pin driver read of empty upper output FIFO sets status.
// [RL24] Reserved status bits ignore writes and read as zero.
// [RL25] Request is OR of set bits gated by their masks; bias-count is ungated.
`timescale 1ns/1ps

`include "lcdsi_params.svh"

module lcdsi_status_irq #(
    parameter int ADDR_W = 12,
    parameter int API_W  = 8,
    parameter int DATA_W = 32
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frame_done,
    input  wire logic              ch1_at_end,
    input  wire logic              ch2_at_end,
    input  wire logic              dma_bus_error,
    input  wire logic              dma_rvalid,
    input  wire logic [DATA_W-1:0] dma_rdata,
    input  wire logic              bias_pin,
    input  wire logic              lower_in_full_write,
    input  wire logic              lower_in_empty_read,
    input  wire logic              upper_in_full_write,
    input  wire logic              upper_in_empty_read,
    input  wire logic              lower_out_full_write,
    input  wire logic              lower_out_empty_read,
    input  wire logic              upper_out_full_write,
    input  wire logic              upper_out_empty_read,
    output logic                   lcd_irq,
    output logic                   controller_active,
    output logic                   reload_ch1,
    output logic                   reload_ch2,
    output logic                   fetch_valid,
    output logic      [DATA_W-1:0] fetch_data
);

    logic [`LCDSI_CTRL_W-1:0] ctrl_reg;
    logic [`LCDSI_ST_W-1:0]   status_reg;
    logic [`LCDSI_ST_W-1:0]   status_set;
    logic [`LCDSI_ST_W-1:0]   status_w1c;
    logic [`LCDSI_ST_W-1:0]   irq_gate;
    logic [API_W-1:0]         api_reg;
    logic [API_W-1:0]         bias_cnt;
    lcdsi_pkg::lcdsi_state_t  st_reg;
    lcdsi_pkg::lcdsi_state_t  st_next;
    logic                     ready_reg;
    logic                     slverr_reg;
    logic [31:0]              rdata_reg;
    logic                     reload1_reg;
    logic                     reload2_reg;
    logic                     got1_reg;
    logic                     got2_reg;
    logic                     bau_set;
    logic                     done_pulse;
    logic                     start;
    logic                     bias_zero;
    logic                     fvalid_reg;
    logic [DATA_W-1:0]        fdata_reg;
    logic                     access;
    logic                     wr_en;
    logic                     mapped;
    logic                     enable_bit;
    logic                     dual;

    assign enable_bit = ctrl_reg[`LCDSI_CTRL_EN];
    assign dual       = ctrl_reg[`LCDSI_CTRL_DUAL];

    // Address decode; anything outside the four words answers with an error.
    assign access = psel & penable;
    assign mapped = (paddr == `LCDSI_OFF_CTRL) || (paddr == `LCDSI_OFF_STATUS) ||
                    (paddr == `LCDSI_OFF_BIAS) || (paddr == `LCDSI_OFF_FLAGS);
    assign wr_en  = access & ready_reg & pwrite & mapped;

    // One wait state gives registered read data without a combinational path to prdata.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg  <= 1'b0;
            slverr_reg <= 1'b0;
            rdata_reg  <= '0;
        end else begin
            ready_reg  <= access & ~ready_reg;
            slverr_reg <= access & ~ready_reg & ~mapped;
            if (access && !ready_reg) begin
                rdata_reg <= '0;
                if (!pwrite) begin
                    case (paddr)
                        `LCDSI_OFF_CTRL:   rdata_reg <= {27'h0000000, ctrl_reg};
                        `LCDSI_OFF_STATUS: rdata_reg <= {20'h00000, status_reg}; // see [RL24]
                        `LCDSI_OFF_BIAS:   rdata_reg <= {24'h000000, api_reg};
                        `LCDSI_OFF_FLAGS:  rdata_reg <= {16'h0000, bias_cnt, 6'h00,
                                                         st_reg[2], controller_active};
                        default:           rdata_reg <= '0;
                    endcase
                end
            end
        end
    end

    assign pready  = ready_reg;
    assign pslverr = slverr_reg;
    assign prdata  = rdata_reg;

    // Software-owned control fields; the flag word has no write path at all.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `LCDSI_CTRL_RST;
            api_reg  <= `LCDSI_BIAS_RST;
        end else if (wr_en) begin
            if (paddr == `LCDSI_OFF_CTRL) begin
                ctrl_reg <= pwdata[`LCDSI_CTRL_W-1:0];
            end
            if (paddr == `LCDSI_OFF_BIAS) begin
                api_reg <= pwdata[API_W-1:0];
            end
        end
    end

    // Run control: enable seen high outside RUN can only follow a zero-to-one change, so it reloads.
    assign start      = (st_reg != lcdsi_pkg::LCDSI_RUN) & enable_bit;  // see [RL7]
    assign done_pulse = (st_reg == lcdsi_pkg::LCDSI_DRAIN) & ~enable_bit & frame_done;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            lcdsi_pkg::LCDSI_IDLE: begin
                if (enable_bit) begin
                    st_next = lcdsi_pkg::LCDSI_RUN;
                end
            end
            lcdsi_pkg::LCDSI_RUN: begin
                if (!enable_bit) begin
                    st_next = lcdsi_pkg::LCDSI_DRAIN;     // see [RL5]
                end
            end
            lcdsi_pkg::LCDSI_DRAIN: begin
                if (enable_bit) begin
                    st_next = lcdsi_pkg::LCDSI_RUN;
                end else if (frame_done) begin
                    st_next = lcdsi_pkg::LCDSI_IDLE;      // see [RL6]
                end
            end
            default: st_next = lcdsi_pkg::LCDSI_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= lcdsi_pkg::LCDSI_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Read-only flag: driven by the state alone, never by a bus write.
    assign controller_active = (st_reg != lcdsi_pkg::LCDSI_IDLE); // see [RL3]

    // Pointer reload commands to the DMA address logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload1_reg <= 1'b0;
            reload2_reg <= 1'b0;
        end else begin
            reload1_reg <= start | (controller_active & ch1_at_end);         // see [RL7]
            reload2_reg <= start | (controller_active & dual & ch2_at_end);  // see [RL7]
        end
    end

    assign reload_ch1 = reload1_reg;
    assign reload_ch2 = reload2_reg;

    // Collect reloads; in dual mode the update is reported only when both channels moved.
    always_comb begin
        if (dual) begin
            bau_set = (got1_reg | reload1_reg) & (got2_reg | reload2_reg); // see [RL9]
        end else begin
            bau_set = reload1_reg;                                         // see [RL8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got1_reg <= 1'b0;
            got2_reg <= 1'b0;
        end else if (bau_set || !dual) begin
            got1_reg <= 1'b0;
            got2_reg <= 1'b0;
        end else begin
            got1_reg <= got1_reg | reload1_reg;
            got2_reg <= got2_reg | reload2_reg;
        end
    end

    lcdsi_bias_counter #(
        .CNT_W      (API_W)
    ) u_bias (
        .pclk       (pclk),
        .presetn    (presetn),
        .bias_pin   (bias_pin),
        .api_field  (api_reg),
        .hold       (status_reg[`LCDSI_ST_ABC]),  // see [RL15]
        .count      (bias_cnt),
        .zero_pulse (bias_zero)
    );

    // Hardware events; lower panel sources only count in dual mode.
    always_comb begin
        status_set                 = '0;
        status_set[`LCDSI_ST_LDD]  = done_pulse;                     // see [RL6]
        status_set[`LCDSI_ST_BAU]  = bau_set;                        // see [RL8]
        status_set[`LCDSI_ST_BER]  = dma_bus_error;                  // see [RL10]
        status_set[`LCDSI_ST_ABC]  = bias_zero;                      // see [RL14]
        status_set[`LCDSI_ST_IOL]  = dual & lower_in_full_write;     // see [RL16]
        status_set[`LCDSI_ST_IUL]  = dual & lower_in_empty_read;     // see [RL17]
        status_set[`LCDSI_ST_IOU]  = upper_in_full_write;            // see [RL18]
        status_set[`LCDSI_ST_IUU]  = upper_in_empty_read;            // see [RL19]
        status_set[`LCDSI_ST_OOL]  = dual & lower_out_full_write;    // see [RL20]
        status_set[`LCDSI_ST_OUL]  = dual & lower_out_empty_read;    // see [RL21]
        status_set[`LCDSI_ST_OOU]  = upper_out_full_write;           // see [RL22]
        status_set[`LCDSI_ST_OUU]  = upper_out_empty_read;           // see [RL23]
    end

    // Write-one-to-clear mask; bits of the reserved range are never looked at.
    assign status_w1c = (wr_en && paddr == `LCDSI_OFF_STATUS) ?
                        pwdata[`LCDSI_ST_W-1:0] : '0;                // see [RL2]

    // Each sticky bit: a set in the clearing cycle wins so no event is lost.
    for (genvar i = 0; i < `LCDSI_ST_W; i++) begin : g_status
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                status_reg[i] <= 1'b0;
            end else begin
                status_reg[i] <= status_set[i] | (status_reg[i] & ~status_w1c[i]); // see [RL2]
            end
        end
    end

    // Per-source enables; the bias count source has no mask.
    always_comb begin
        irq_gate                = {`LCDSI_ST_W{~ctrl_reg[`LCDSI_CTRL_ERM]}};
        irq_gate[`LCDSI_ST_LDD] = ~ctrl_reg[`LCDSI_CTRL_LDM];
        irq_gate[`LCDSI_ST_BAU] = ~ctrl_reg[`LCDSI_CTRL_BAM];
        irq_gate[`LCDSI_ST_ABC] = 1'b1;                              // see [RL25]
    end

    // Level request straight from the bits, so it falls in the cycle the last one clears.
    assign lcd_irq = |(status_reg & irq_gate);                       // see [RL1]

    // Fetched words pass on whether the bus errored or not; an error read brings zeros.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fvalid_reg <= 1'b0;
            fdata_reg  <= '0;
        end else begin
            fvalid_reg <= dma_rvalid;                                // see [RL11]
            if (dma_rvalid) begin
                fdata_reg <= dma_rdata;                              // see [RL12]
            end
        end
    end

    assign fetch_valid = fvalid_reg;
    assign fetch_data  = fdata_reg;

    // Checks kept beside the logic.
    chk_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (status_w1c != '0 && status_set == '0 && (status_reg & ~status_w1c & irq_gate) == '0)
        |=> !lcd_irq)                                                // see [RL1]
        else $error("Interrupt high with no enabled status bit.");

    chk_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `LCDSI_OFF_STATUS && pwdata[`LCDSI_ST_BER] && !dma_bus_error)
        |=> !status_reg[`LCDSI_ST_BER])                              // see [RL2]
        else $error("Bus error status survived a write of one.");

    chk_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `LCDSI_OFF_STATUS && !pwdata[`LCDSI_ST_IOU] &&
         status_reg[`LCDSI_ST_IOU]) |=> status_reg[`LCDSI_ST_IOU])   // see [RL2]
        else $error("Writing zero cleared a status bit.");

    chk_flag_ro: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `LCDSI_OFF_FLAGS && st_reg == lcdsi_pkg::LCDSI_RUN && enable_bit)
        |=> controller_active)                                       // see [RL3]
        else $error("A flag write changed the active flag.");

    chk_drain_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg == lcdsi_pkg::LCDSI_RUN && !enable_bit && !frame_done)
        |=> controller_active [*1] ##0 (st_reg == lcdsi_pkg::LCDSI_DRAIN)) // see [RL5]
        else $error("Controller stopped before frame end.");

    chk_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        done_pulse |=> !controller_active && status_reg[`LCDSI_ST_LDD]) // see [RL6]
        else $error("Disable done not reported at frame end.");

    chk_start_reload: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(enable_bit) |=> reload_ch1 && reload_ch2 ##1 status_reg[`LCDSI_ST_BAU]) // see [RL7]
        else $error("Enable rise did not reload both pointers.");

    chk_bau_dual: assert property (@(posedge pclk) disable iff (!presetn)
        (dual && reload_ch1 && !reload_ch2 && !got2_reg && !status_reg[`LCDSI_ST_BAU])
        |=> !status_reg[`LCDSI_ST_BAU])                              // see [RL9]
        else $error("Base update set before both channels reloaded.");

    chk_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
        dma_bus_error |=> status_reg[`LCDSI_ST_BER] &&
        (lcd_irq || ctrl_reg[`LCDSI_CTRL_ERM]))                      // see [RL10]
        else $error("Bus error not recorded.");

    chk_bias_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (status_reg[`LCDSI_ST_ABC] && api_reg != '0) |=> bias_cnt == $past(api_reg)) // see [RL15]
        else $error("Bias counter moved while status pending.");

    chk_bias_irq: assert property (@(posedge pclk) disable iff (!presetn)
        bias_zero |-> ##1 (status_reg[`LCDSI_ST_ABC] && lcd_irq))    // see [RL14]
        else $error("Bias count event raised no request.");

    chk_lower_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!dual && !status_reg[`LCDSI_ST_OUL]) |=> !status_reg[`LCDSI_ST_OUL]) // see [RL21]
        else $error("Lower panel status set in single mode.");

    chk_fetch_pass: assert property (@(posedge pclk) disable iff (!presetn)
        dma_rvalid |=> fetch_valid && fetch_data == $past(dma_rdata)) // see [RL12]
        else $error("Fetched word not passed on.");

endmodule : lcdsi_status_irq

// ===== testbench/lcdsi_intc_model.sv
// Model of the interrupt controller input that receives the display request.
`timescale 1ns/1ps

module lcdsi_intc_model (
    input  wire logic lcd_irq,
    input  wire logic mask_bit12,
    output logic      cpu_irq
);
    // The request reaches the processor only while the mask bit lets it through.
    assign cpu_irq = lcd_irq & mask_bit12;
endmodule : lcdsi_intc_model

// ===== testbench/lcd_status_interrupt_logic_tb.sv
// Self-checking bench of the display status and interrupt request block.
`timescale 1ns/1ps
`include "lcdsi_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: got %h exp %h", $time, g, e); end end

module lcd_status_interrupt_logic_tb;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err, intc_mask;
    logic        frame_done, ch1_at_end, ch2_at_end, dma_rvalid, bias_pin;
    logic        lcd_irq, controller_active, reload_ch1, reload_ch2, fetch_valid, cpu_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dma_rdata, fetch_data, rd;
    logic [8:0]  ev;
    logic [25:0] rows [14];
    int          mismatches, num_checks, i;

    // The clock toggles every half period of 2.5 ns.
    initial forever #2.5 pclk = ~pclk;

    lcdsi_status_irq i_lcdsi_status_irq (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_done(frame_done), .ch1_at_end(ch1_at_end), .ch2_at_end(ch2_at_end),
        .dma_bus_error(ev[8]), .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .bias_pin(bias_pin),
        .lower_in_full_write(ev[0]), .lower_in_empty_read(ev[1]), .upper_in_full_write(ev[2]),
        .upper_in_empty_read(ev[3]), .lower_out_full_write(ev[4]), .lower_out_empty_read(ev[5]),
        .upper_out_full_write(ev[6]), .upper_out_empty_read(ev[7]), .lcd_irq(lcd_irq),
        .controller_active(controller_active), .reload_ch1(reload_ch1), .reload_ch2(reload_ch2),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data)
    );

    lcdsi_intc_model i_lcdsi_intc_model (.lcd_irq(lcd_irq), .mask_bit12(intc_mask), .cpu_irq(cpu_irq));

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            mismatches++;
            finish_test();
        end
    endtask : apb

    // Pulses one strobe for a single cycle.
    task automatic pulse(input int s);
        @(posedge pclk);
        if (s == 0) ch1_at_end <= 1'b1; else if (s == 1) ch2_at_end <= 1'b1; else frame_done <= 1'b1;
        @(posedge pclk);
        {ch1_at_end, ch2_at_end, frame_done} <= 3'h0;
        @(negedge pclk);
    endtask : pulse

    // Bounded wait for the channel one reload; a miss counts and ends the run.
    task automatic wait_reload();
        int k;
        for (k = 0; k < 10 && reload_ch1 !== 1'b1; k++) @(negedge pclk);
        if (k == 10) begin
            mismatches++;
            finish_test();
        end
    endtask : wait_reload

    // Reverses the bias pin n times, spaced so that each reversal is seen alone.
    task automatic tog(input int cnt);
        repeat (cnt) begin
            @(posedge pclk);
            bias_pin <= ~bias_pin;
            repeat (2) @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask : tog

    initial begin
        {presetn, psel, penable, pwrite, frame_done, ch1_at_end, ch2_at_end, dma_rvalid, bias_pin} = '0;
        {paddr, pwdata, dma_rdata, ev} = '0;
        intc_mask = 1'b1;
        // Control, event strobes and the status each strobe must leave behind.
        rows = '{{5'h02, 9'h001, 12'h010}, {5'h00, 9'h001, 12'h000}, {5'h02, 9'h002, 12'h020},
                 {5'h00, 9'h002, 12'h000}, {5'h00, 9'h004, 12'h040}, {5'h00, 9'h008, 12'h080},
                 {5'h02, 9'h010, 12'h100}, {5'h00, 9'h010, 12'h000}, {5'h02, 9'h020, 12'h200},
                 {5'h00, 9'h040, 12'h400}, {5'h00, 9'h080, 12'h800}, {5'h00, 9'h100, 12'h004},
                 {5'h00, 9'h020, 12'h000}, {5'h10, 9'h100, 12'h004}};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            `CHK(rd, 32'h0)
        end
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        for (i = 0; i < 14; i++) begin
            apb(1'b1, `LCDSI_OFF_CTRL, {27'h0, rows[i][25:21]});
            @(posedge pclk) ev <= rows[i][20:12];
            @(posedge pclk) ev <= '0;
            @(negedge pclk);
            `CHK(lcd_irq, |rows[i][11:0] & !rows[i][25])
            `CHK(cpu_irq, lcd_irq)
            apb(1'b1, `LCDSI_OFF_STATUS, 32'h0);
            apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
            `CHK(rd, {20'h0, rows[i][11:0]})
            apb(1'b1, `LCDSI_OFF_STATUS, 32'hffffffff);
            apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
            `CHK(rd, 32'h0)
            `CHK(lcd_irq, 1'b0)
        end
        // Enabling reloads both pointers and reports the base update.
        apb(1'b1, `LCDSI_OFF_CTRL, 32'h1);
        wait_reload();
        `CHK(reload_ch2, 1'b1)
        apb(1'b1, `LCDSI_OFF_FLAGS, 32'h0);
        apb(1'b0, `LCDSI_OFF_FLAGS, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b1, `LCDSI_OFF_STATUS, 32'h2);
        pulse(0);
        wait_reload();
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h2)
        // In dual mode the update waits for the second channel.
        apb(1'b1, `LCDSI_OFF_STATUS, 32'h2);
        apb(1'b1, `LCDSI_OFF_CTRL, 32'h3);
        pulse(0);
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        pulse(1);
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b1, `LCDSI_OFF_STATUS, 32'hffffffff);
        apb(1'b1, `LCDSI_OFF_CTRL, 32'h2);
        repeat (3) @(negedge pclk);
        `CHK(controller_active, 1'b1)
        pulse(2);
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h1)
        `CHK(controller_active, 1'b0)
        `CHK(lcd_irq, 1'b1)
        apb(1'b1, `LCDSI_OFF_STATUS, 32'h1);
        // Bias count fires with every mask set and holds until cleared.
        apb(1'b1, `LCDSI_OFF_CTRL, 32'h1c);
        apb(1'b1, `LCDSI_OFF_BIAS, 32'h2);
        tog(2);
        `CHK(lcd_irq, 1'b1)
        tog(1);
        apb(1'b1, `LCDSI_OFF_STATUS, 32'h8);
        tog(1);
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        tog(1);
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h8)
        apb(1'b1, `LCDSI_OFF_STATUS, 32'h8);
        // A good word first, so the failed fetch must visibly replace it with zeros.
        apb(1'b1, `LCDSI_OFF_CTRL, 32'h0);
        @(posedge pclk) {dma_rvalid, dma_rdata} <= {1'b1, 32'hffffffff};
        @(posedge pclk) {dma_rvalid, ev[8], dma_rdata} <= {2'h3, 32'h0};
        @(posedge pclk) {dma_rvalid, ev[8]} <= 2'h0;
        @(negedge pclk);
        `CHK(fetch_valid, 1'b1)
        `CHK(fetch_data, 32'h0)
        intc_mask <= 1'b0;
        @(negedge pclk);
        `CHK(lcd_irq, 1'b1)
        `CHK(cpu_irq, 1'b0)
        // A reset in mid-run drops the request and empties the status word.
        @(posedge pclk) presetn <= 1'b0;
        @(negedge pclk);
        `CHK(lcd_irq, 1'b0)
        @(posedge pclk) presetn <= 1'b1;
        apb(1'b0, `LCDSI_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        finish_test();
    end
endmodule : lcd_status_interrupt_logic_tb
